// *** hdl/lvpc_top.sv ***
// Local video port control: registers, sync handling, FIFO status, burst and drain requests
`default_nettype none
// Summary of operation
// - Once enabled, port resets only by system reset or the port reset bit.
// - Three-bit mode field selects handshake, 16-bit, 8-bit, bidirectional or pass-through.
// - Pass-through forwards output FIFO words into the video FIFO decimation input.
// - Frame skip stores only odd frames; otherwise every frame is stored.
// - Byte order bit zero swaps chroma-first bytes; one passes luma-first unchanged.
// - Sync polarity bits: one means active high, zero means active low.
// - Software vertical sync write does every vertical sync action, applying deferred values.
// - Software horizontal sync write does every horizontal sync action.
// - Base address load write immediately loads the selected base address.
// - Handshake mode bursts one, two, three or eight words, stopping early when the output FIFO empties.
// - Request video FIFO drain when filled slots reach threshold 1, 2, 4, 6.
// - Clock source bit picks system clock or dedicated port clock.
// - Clock invert applies to dedicated clock only when it is selected.
// - Sync non-overlap suppresses stride on first horizontal sync of frame.
// - Top mode bit reads decoder FIFO level input in bidirectional mode.
// - Low status nibble reports free output FIFO slots, reset to eight.
// - Output FIFO full, empty, almost-empty flags; almost-empty means one slot.
// - Each video FIFO has full, empty, almost-empty flags likewise.
// - Latch status on output FIFO empty, horizontal sync, vertical sync.
// - Writing one clears a latched status bit; zero leaves it.
// - Latch serial start on data falling while clock not low; write one clears.
// - Four mask bits enable output empty, line end, frame end, serial start.
module lvpc_top (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               link_clk,
  input  wire logic               link_resetn,
  input  wire lvpc_pkg::lvpc_req_t reg_req,
  output logic [31:0]             reg_rdata,
  input  wire logic               hsync_pin,
  input  wire logic               vsync_pin,
  input  wire logic [15:0]        port_data_lines,
  input  wire logic               port_data_valid,
  input  wire logic               decoder_fifo_level_input,
  input  wire logic               serial_clock_pin,
  input  wire logic               serial_data_pin,
  input  wire logic               out_push,
  input  wire logic [31:0]        out_push_data,
  input  wire logic               vid_pop,
  input  wire logic               video_request_ready,
  output logic                    burst_active,
  output logic                    burst_pop,
  output logic                    drain_request,
  output logic [31:0]             vid_word,
  output logic                    vid_word_valid,
  output logic                    frame_store_enable,
  output logic                    stride_add,
  output logic                    base_address_load,
  output logic                    port_clock_select,
  output logic                    port_clock_invert,
  output logic                    port_active,
  output logic [2:0]              port_mode,
  output logic                    irq
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0]        mode_q;
  logic [3:0]         irq_flags_q;
  logic [3:0]         irq_mask_q;
  lvpc_pkg::lvpc_fill_t fill_q;
  logic               port_rst;
  logic               wr_mode;
  logic               wr_irq;
  logic               sw_vs;
  logic               sw_hs;
  logic               sw_ba;
  logic               vs_evt;
  logic               hs_evt;
  logic               odd_frame_q;
  logic               first_hs_q;
  logic               out_empty_d1_q;
  logic               out_empty;
  logic               spstart_evt;
  logic [1:0]         sc_sync_q;
  logic [1:0]         sd_sync_q;
  logic               sd_prev_q;
  logic [1:0]         dfl_sync_q;
  logic               vid_sel_q;
  lvpc_pkg::lvpc_burst_t bstate_q;
  logic [3:0]         bcount_q;
  logic [3:0]         bmax;
  logic [3:0]         vft_slots;
  logic [3:0]         vid_active_fill;
  logic [2:0]         mode_f;
  logic               out_pop;
  logic               vid_push;
  logic [31:0]        link_word_q;
  logic               link_tog_q;
  logic [15:0]        link_half_q;
  logic               link_half_v_q;
  logic               link_hs_tog_q;
  logic               link_vs_tog_q;
  logic [1:0]         hs_meta_q;
  logic [1:0]         vs_meta_q;
  logic               hs_prev_q;
  logic               vs_prev_q;
  logic [2:0]         wtog_sync_q;
  logic [2:0]         htog_sync_q;
  logic [2:0]         vtog_sync_q;
  logic [1:0]         lrst_sync_q;
  logic [31:0]        link_word_hold;
  logic               link_word_evt;
  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  always_comb begin
    wr_mode = 1'b0;
    wr_irq  = 1'b0;
    if (reg_req.wr && reg_req.addr == lvpc_pkg::LVPC_OFF_MODE) begin
      wr_mode = 1'b1;
    end else if (reg_req.wr && reg_req.addr == lvpc_pkg::LVPC_OFF_IRQ) begin
      wr_irq = 1'b1;
    end
  end
  assign sw_vs    = wr_mode & reg_req.wdata[lvpc_pkg::LVPC_B_SWVS];
  assign sw_hs    = wr_mode & reg_req.wdata[lvpc_pkg::LVPC_B_SWHS];
  assign sw_ba    = wr_mode & reg_req.wdata[lvpc_pkg::LVPC_B_BALOAD];
  assign port_rst = mode_q[lvpc_pkg::LVPC_B_RESET];
  assign mode_f   = mode_q[lvpc_pkg::LVPC_B_MODE_LO +: 3];
  // Mode register; strobe bits are never stored
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= lvpc_pkg::LVPC_RST_MODE;
    end else if (wr_mode) begin
      mode_q <= reg_req.wdata & lvpc_pkg::LVPC_MODE_WMASK;
    end
  end
  always_comb begin
    reg_rdata = 32'h00000000;
    if (reg_req.addr == lvpc_pkg::LVPC_OFF_MODE) begin
      reg_rdata = mode_q;
      reg_rdata[lvpc_pkg::LVPC_B_DFL] = (mode_f == lvpc_pkg::LVPC_MODE_BIDIR8) & dfl_sync_q[1];
    end else if (reg_req.addr == lvpc_pkg::LVPC_OFF_STATUS) begin
      reg_rdata[3:0] = lvpc_pkg::LVPC_OUT_DEPTH - fill_q.out_fill;
      reg_rdata[lvpc_pkg::LVPC_B_OFF]  = fill_q.out_fill == lvpc_pkg::LVPC_OUT_DEPTH;
      reg_rdata[lvpc_pkg::LVPC_B_OFE]  = fill_q.out_fill == 4'h0;
      reg_rdata[lvpc_pkg::LVPC_B_OUT_FIFO_ALMOST_EMPTY_FLAG] = fill_q.out_fill == 4'h1;
      reg_rdata[lvpc_pkg::LVPC_B_VAF]     = fill_q.vida_fill == lvpc_pkg::LVPC_VID_DEPTH;
      reg_rdata[lvpc_pkg::LVPC_B_VAF + 1] = fill_q.vida_fill == 4'h0;
      reg_rdata[lvpc_pkg::LVPC_B_VAF + 2] = fill_q.vida_fill == 4'h1;
      reg_rdata[lvpc_pkg::LVPC_B_VBF]     = fill_q.vidb_fill == lvpc_pkg::LVPC_VID_DEPTH;
      reg_rdata[lvpc_pkg::LVPC_B_VBF + 1] = fill_q.vidb_fill == 4'h0;
      reg_rdata[lvpc_pkg::LVPC_B_VBF + 2] = fill_q.vidb_fill == 4'h1;
    end else if (reg_req.addr == lvpc_pkg::LVPC_OFF_IRQ) begin
      reg_rdata[3:0] = irq_flags_q;
      reg_rdata[lvpc_pkg::LVPC_B_MASK_LO +: 4] = irq_mask_q;
    end
  end
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sc_sync_q  <= 2'h0;
      sd_sync_q  <= 2'h3;
      dfl_sync_q <= 2'h0;
      sd_prev_q  <= 1'b1;
    end else begin
      sc_sync_q  <= {sc_sync_q[0], serial_clock_pin};
      sd_sync_q  <= {sd_sync_q[0], serial_data_pin};
      dfl_sync_q <= {dfl_sync_q[0], decoder_fifo_level_input};
      sd_prev_q  <= sd_sync_q[1];
    end
  end
  assign spstart_evt = sd_prev_q & ~sd_sync_q[1] & sc_sync_q[1];
  // ---------------------------------------------------------------
  // Link domain: sync polarity, byte order, word packing
  // ---------------------------------------------------------------
  logic link_cbo;
  logic link_vpol;
  logic link_hpol;
  logic link_wide;
  logic [15:0] link_sw;
  always_ff @(posedge link_clk or negedge link_resetn) begin
    if (!link_resetn) begin
      lrst_sync_q <= 2'h0;
    end else begin
      lrst_sync_q <= {lrst_sync_q[0], port_active};
    end
  end
  // Quasi-static configuration, changed only while the port is held in reset
  assign link_cbo  = mode_q[lvpc_pkg::LVPC_B_CBO];
  assign link_vpol = mode_q[lvpc_pkg::LVPC_B_VPOL];
  assign link_hpol = mode_q[lvpc_pkg::LVPC_B_HPOL];
  assign link_wide = mode_f == lvpc_pkg::LVPC_MODE_DIG16;
  assign link_sw   = link_cbo ? port_data_lines : {port_data_lines[7:0], port_data_lines[15:8]};
  always_ff @(posedge link_clk or negedge link_resetn) begin
    if (!link_resetn) begin
      hs_meta_q     <= 2'h0;
      vs_meta_q     <= 2'h0;
      hs_prev_q     <= 1'b0;
      vs_prev_q     <= 1'b0;
      link_hs_tog_q <= 1'b0;
      link_vs_tog_q <= 1'b0;
    end else begin
      hs_meta_q <= {hs_meta_q[0], hsync_pin};
      vs_meta_q <= {vs_meta_q[0], vsync_pin};
      hs_prev_q <= hs_meta_q[1] ~^ link_hpol;
      vs_prev_q <= vs_meta_q[1] ~^ link_vpol;
      if (lrst_sync_q[1] && (hs_meta_q[1] ~^ link_hpol) && !hs_prev_q) begin
        link_hs_tog_q <= ~link_hs_tog_q;
      end
      if (lrst_sync_q[1] && (vs_meta_q[1] ~^ link_vpol) && !vs_prev_q) begin
        link_vs_tog_q <= ~link_vs_tog_q;
      end
    end
  end
  always_ff @(posedge link_clk or negedge link_resetn) begin
    if (!link_resetn) begin
      link_half_q   <= 16'h0000;
      link_half_v_q <= 1'b0;
      link_word_q   <= 32'h00000000;
      link_tog_q    <= 1'b0;
    end else if (!lrst_sync_q[1]) begin
      link_half_v_q <= 1'b0;
    end else if (port_data_valid) begin
      if (link_wide && link_half_v_q) begin
        link_word_q   <= {link_sw, link_half_q};
        link_tog_q    <= ~link_tog_q;
        link_half_v_q <= 1'b0;
      end else if (!link_wide && link_half_v_q) begin
        link_word_q   <= {16'h0000, link_sw[7:0], link_half_q[7:0]};
        link_tog_q    <= ~link_tog_q;
        link_half_v_q <= 1'b0;
      end else begin
        link_half_q   <= link_sw;
        link_half_v_q <= 1'b1;
      end
    end
  end
  // ---------------------------------------------------------------
  // Crossing into the system domain
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wtog_sync_q    <= 3'h0;
      htog_sync_q    <= 3'h0;
      vtog_sync_q    <= 3'h0;
      link_word_hold <= 32'h00000000;
    end else begin
      wtog_sync_q <= {wtog_sync_q[1:0], link_tog_q};
      htog_sync_q <= {htog_sync_q[1:0], link_hs_tog_q};
      vtog_sync_q <= {vtog_sync_q[1:0], link_vs_tog_q};
      if (wtog_sync_q[2] != wtog_sync_q[1]) begin
        link_word_hold <= link_word_q;
      end
    end
  end
  assign link_word_evt = wtog_sync_q[2] != wtog_sync_q[1];
  assign hs_evt = (htog_sync_q[2] != htog_sync_q[1]) | sw_hs;
  assign vs_evt = (vtog_sync_q[2] != vtog_sync_q[1]) | sw_vs;
  // ---------------------------------------------------------------
  // Port control, frame skip, stride, clocking
  // ---------------------------------------------------------------
  assign port_active       = mode_q[lvpc_pkg::LVPC_B_ENABLE] & ~port_rst;
  assign port_mode         = mode_f;
  assign port_clock_select = mode_q[lvpc_pkg::LVPC_B_CLKSRC];
  assign port_clock_invert = mode_q[lvpc_pkg::LVPC_B_CLKSRC] & mode_q[lvpc_pkg::LVPC_B_CLKINV];
  assign frame_store_enable = port_active & (~mode_q[lvpc_pkg::LVPC_B_SKIP] | odd_frame_q);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      odd_frame_q       <= 1'b1;
      first_hs_q        <= 1'b0;
      stride_add        <= 1'b0;
      base_address_load <= 1'b0;
      vid_sel_q         <= 1'b0;
    end else if (port_rst) begin
      odd_frame_q       <= 1'b1;
      first_hs_q        <= 1'b0;
      stride_add        <= 1'b0;
      base_address_load <= 1'b0;
      vid_sel_q         <= 1'b0;
    end else begin
      base_address_load <= sw_ba | vs_evt;
      stride_add        <= hs_evt & ~(first_hs_q & mode_q[lvpc_pkg::LVPC_B_SNO]);
      if (vs_evt) begin
        odd_frame_q <= ~odd_frame_q;
        first_hs_q  <= 1'b1;
        vid_sel_q   <= ~vid_sel_q;
      end else if (hs_evt) begin
        first_hs_q <= 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------
  // Output FIFO drain: handshake bursts and pass-through
  // ---------------------------------------------------------------
  always_comb begin
    case (mode_q[lvpc_pkg::LVPC_B_BURST_LO +: 2])
      2'h0:    bmax = 4'h1;
      2'h1:    bmax = 4'h2;
      2'h2:    bmax = 4'h3;
      default: bmax = lvpc_pkg::LVPC_OUT_DEPTH;
    endcase
  end
  assign burst_active = bstate_q == lvpc_pkg::LVPC_BS_BURST;
  assign burst_pop    = burst_active & video_request_ready & (fill_q.out_fill != 4'h0);
  assign out_pop      = burst_pop | (port_active & (mode_f == lvpc_pkg::LVPC_MODE_PASS) &
                        (fill_q.out_fill != 4'h0) & (vid_active_fill != lvpc_pkg::LVPC_VID_DEPTH));
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bstate_q <= lvpc_pkg::LVPC_BS_IDLE;
      bcount_q <= 4'h0;
    end else if (port_rst || !port_active || mode_f != lvpc_pkg::LVPC_MODE_HANDSHAKE) begin
      bstate_q <= lvpc_pkg::LVPC_BS_IDLE;
      bcount_q <= 4'h0;
    end else begin
      case (bstate_q)
        lvpc_pkg::LVPC_BS_IDLE: begin
          if (fill_q.out_fill != 4'h0) begin
            bstate_q <= lvpc_pkg::LVPC_BS_BURST;
            bcount_q <= 4'h0;
          end
        end
        default: begin
          if (burst_pop) begin
            bcount_q <= bcount_q + 4'h1;
            if (bcount_q + 4'h1 == bmax || fill_q.out_fill == 4'h1) begin
              bstate_q <= lvpc_pkg::LVPC_BS_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Video FIFO fill tracking and drain request
  // ---------------------------------------------------------------
  always_comb begin
    case (mode_q[lvpc_pkg::LVPC_B_VFT_LO +: 2])
      2'h0:    vft_slots = 4'h1;
      2'h1:    vft_slots = 4'h2;
      2'h2:    vft_slots = 4'h4;
      default: vft_slots = 4'h6;
    endcase
  end

  assign vid_active_fill = vid_sel_q ? fill_q.vidb_fill : fill_q.vida_fill;
  assign vid_push = (out_pop & (mode_f == lvpc_pkg::LVPC_MODE_PASS)) |
                    (link_word_evt & frame_store_enable & (vid_active_fill != lvpc_pkg::LVPC_VID_DEPTH));
  assign drain_request = vid_active_fill >= vft_slots;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fill_q         <= '0;
      vid_word       <= 32'h00000000;
      vid_word_valid <= 1'b0;
    end else if (port_rst) begin
      fill_q         <= '0;
      vid_word_valid <= 1'b0;
    end else begin
      vid_word_valid <= vid_push;
      if (vid_push) begin
        vid_word <= (mode_f == lvpc_pkg::LVPC_MODE_PASS) ? out_push_data : link_word_hold;
      end
      fill_q.out_fill <= fill_q.out_fill
        + 4'((out_push && fill_q.out_fill != lvpc_pkg::LVPC_OUT_DEPTH) ? 1 : 0)
        - 4'(out_pop ? 1 : 0);
      if (!vid_sel_q) begin
        fill_q.vida_fill <= fill_q.vida_fill + 4'(vid_push ? 1 : 0)
          - 4'((vid_pop && fill_q.vida_fill != 4'h0) ? 1 : 0);
      end else begin
        fill_q.vidb_fill <= fill_q.vidb_fill + 4'(vid_push ? 1 : 0)
          - 4'((vid_pop && fill_q.vidb_fill != 4'h0) ? 1 : 0);
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt flags and masks
  // ---------------------------------------------------------------
  assign out_empty = fill_q.out_fill == 4'h0;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_flags_q    <= lvpc_pkg::LVPC_RST_IRQ[3:0];
      irq_mask_q     <= lvpc_pkg::LVPC_RST_IRQ[19:16];
      out_empty_d1_q <= 1'b1;
    end else begin
      out_empty_d1_q <= out_empty;
      if (wr_irq) begin
        irq_mask_q <= reg_req.wdata[lvpc_pkg::LVPC_B_MASK_LO +: 4];
      end
      // Set wins over a same-cycle clear
      irq_flags_q <= (irq_flags_q & ~(wr_irq ? reg_req.wdata[3:0] : 4'h0))
                   | {spstart_evt, vs_evt, hs_evt, out_empty & ~out_empty_d1_q};
    end
  end
  assign irq = |(irq_flags_q & irq_mask_q);
endmodule : lvpc_top
`default_nettype wire

// *** hdl/lvpc_pkg.sv ***
// Package of constants and types for the local video port control block
`default_nettype none
package lvpc_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] LVPC_OFF_MODE   = 16'hFF00;
  localparam logic [15:0] LVPC_OFF_STATUS = 16'hFF04;
  localparam logic [15:0] LVPC_OFF_IRQ    = 16'hFF08;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] LVPC_RST_MODE   = 32'h00000000;
  localparam logic [31:0] LVPC_RST_IRQ    = 32'h00000000;
  localparam logic [3:0]  LVPC_OUT_DEPTH  = 4'h8;
  localparam logic [3:0]  LVPC_VID_DEPTH  = 4'h8;
  // ---------------------------------------------------------------
  // Mode register fields
  // ---------------------------------------------------------------
  localparam int LVPC_B_ENABLE   = 0;
  localparam int LVPC_B_MODE_LO  = 1;
  localparam int LVPC_B_RESET    = 4;
  localparam int LVPC_B_SKIP     = 5;
  localparam int LVPC_B_CBO      = 6;
  localparam int LVPC_B_VPOL     = 9;
  localparam int LVPC_B_HPOL     = 10;
  localparam int LVPC_B_SWVS     = 11;
  localparam int LVPC_B_SWHS     = 12;
  localparam int LVPC_B_BALOAD   = 13;
  localparam int LVPC_B_BURST_LO = 16;
  localparam int LVPC_B_VFT_LO   = 21;
  localparam int LVPC_B_CLKSRC   = 24;
  localparam int LVPC_B_SNO      = 25;
  localparam int LVPC_B_CLKINV   = 26;
  localparam int LVPC_B_DFL      = 31;
  // Writable bits of the mode register
  localparam logic [31:0] LVPC_MODE_WMASK = 32'h0763067F;
  // ---------------------------------------------------------------
  // Status and interrupt fields
  // ---------------------------------------------------------------
  localparam int LVPC_B_OFF  = 11;
  localparam int LVPC_B_OFE  = 12;
  localparam int LVPC_B_OUT_FIFO_ALMOST_EMPTY_FLAG = 13;
  localparam int LVPC_B_VAF  = 20;
  localparam int LVPC_B_VBF  = 29;
  localparam int LVPC_B_MASK_LO = 16;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LVPC_MODE_HANDSHAKE = 3'h0,
    LVPC_MODE_DIG16     = 3'h1,
    LVPC_MODE_VID8      = 3'h2,
    LVPC_MODE_BIDIR8    = 3'h3,
    LVPC_MODE_PASS      = 3'h4
  } lvpc_mode_t;
  typedef enum logic [1:0] {
    LVPC_BS_IDLE  = 2'h0,
    LVPC_BS_BURST = 2'h1
  } lvpc_burst_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } lvpc_req_t;
  typedef struct packed {
    logic [3:0] out_fill;
    logic [3:0] vida_fill;
    logic [3:0] vidb_fill;
  } lvpc_fill_t;
endpackage : lvpc_pkg
`default_nettype wire

// *** tb/lvpc_checker.sv ***
// Checker of readback relations and output strobes
`default_nettype none
module lvpc_checker (
  input wire logic                clk,
  input wire logic                resetn,
  input wire lvpc_pkg::lvpc_req_t reg_req,
  input wire logic [31:0]         reg_rdata,
  input wire logic                burst_pop,
  input wire logic                burst_active,
  input wire logic                base_address_load,
  input wire logic                port_clock_select,
  input wire logic                port_clock_invert,
  input wire logic [2:0]          port_mode,
  input wire logic                irq
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [31:0] d  = reg_rdata;
  wire logic        am = reg_req.addr == lvpc_pkg::LVPC_OFF_MODE;
  wire logic        as = reg_req.addr == lvpc_pkg::LVPC_OFF_STATUS;
  wire logic        ai = reg_req.addr == lvpc_pkg::LVPC_OFF_IRQ;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  irq_mask_a: assert property (ai |-> irq == |(d[3:0] & d[19:16])) else $error("irq mask");
  free_range_a: assert property (as |-> d[3:0] <= 4'h8) else $error("free count");
  out_flags_a: assert property (as |-> d[12] == (d[3:0] == 4'h8) && d[11] == (d[3:0] == 4'h0))
    else $error("out flags");
  almost_empty_a: assert property (as |-> d[13] == (d[3:0] == 4'h7)) else $error("almost empty");
  vid_flags_a: assert property (as |-> !(d[20] && d[21]) && !(d[21] && d[22]) && !(d[29] && d[30]))
    else $error("video flags");
  wo_bits_a: assert property (am |-> d[13:11] == 3'h0) else $error("write-only bits");
  mode_out_a: assert property (am |-> port_mode == d[3:1] && port_clock_select == d[24])
    else $error("mode outputs");
  clk_inv_a: assert property (am |-> port_clock_invert == (d[26] && d[24])) else $error("clock invert");
  base_load_a: assert property (reg_req.wr && am && reg_req.wdata[13] |=> base_address_load)
    else $error("base load");
  burst_pop_a: assert property (burst_pop |-> burst_active && port_mode == 3'h0) else $error("pop outside burst");
endmodule : lvpc_checker
`default_nettype wire

// *** tb/lvpc_decoder.sv ***
// Decoder model answering compressed-data bursts with ready
`default_nettype none
module lvpc_decoder (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       slow,
  input  wire logic       burst_pop,
  output logic            ready,
  output logic [7:0]      words
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ph_q  <= 2'h0;
      words <= 8'h00;
    end else begin
      ph_q <= ph_q + 2'h1;
      if (burst_pop) words <= words + 8'h01;
    end
  end
  // Slow decoder is ready one cycle in four
  assign ready = !slow || ph_q == 2'h3;
endmodule : lvpc_decoder
`default_nettype wire

// *** tb/lvpc_tb.sv ***
// Testbench of the local video port control block
`default_nettype none
module lvpc_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [15:0] a; logic [31:0] w, m, e;} lvpc_row_t;
  lvpc_row_t rows [6] = '{'{16'hFF00, 32'hFFFFFFFF, 32'hFFFFFFFF, lvpc_pkg::LVPC_MODE_WMASK},
    '{16'hFF08, 32'hFFFFFFFF, 32'h000F0000, 32'h000F0000}, '{16'hFF04, 32'hFFFFFFFF, 32'h0000380F, 32'h00001008},
    '{16'hFF0C, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00000000}, '{16'hFF08, 32'h00000000, 32'h000F0000, 32'h00000000},
    '{16'hFF00, 32'h00000000, 32'hFFFFFFFF, 32'h00000000}};
  logic clk = 1'b0, dedicated_port_clock = 1'b0, resetn = 1'b0, hs = 1'b1, vs = 1'b1, sda = 1'b1, push = 1'b0, slow = 1'b1;
  logic ready, bact, bpop, irq, vwv, drq, dfl = 1'b0;
  logic [31:0] rdata, vw;
  logic [7:0] words;
  logic [3:0] run = 4'h0, mx = 4'h0;
  lvpc_pkg::lvpc_req_t req = '{1'b0, 1'b0, 16'hFF08, 32'h0};
  int err_count = 0, n_checks = 0, cyc = 0;
  always #20 clk = ~clk;
  initial #1.3 forever #3 dedicated_port_clock = ~dedicated_port_clock;
  lvpc_top DUT (.clk(clk), .resetn(resetn), .link_clk(dedicated_port_clock), .link_resetn(resetn), .reg_req(req),
    .reg_rdata(rdata), .hsync_pin(hs), .vsync_pin(vs), .port_data_lines(16'h0000), .port_data_valid(1'b0),
    .decoder_fifo_level_input(dfl), .serial_clock_pin(1'b1), .serial_data_pin(sda), .out_push(push),
    .out_push_data(32'hA5A50000), .vid_pop(1'b0), .video_request_ready(ready), .burst_active(bact),
    .burst_pop(bpop), .drain_request(drq), .vid_word(vw), .vid_word_valid(vwv), .frame_store_enable(),
    .stride_add(), .base_address_load(), .port_clock_select(), .port_clock_invert(), .port_active(), .port_mode(),
    .irq(irq));
  lvpc_decoder PM (.clk(clk), .resetn(resetn), .slow(slow), .burst_pop(bpop), .ready(ready), .words(words));
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(negedge clk);
    req = '{1'b1, 1'b0, a, v};
    @(negedge clk);
    req = '{1'b0, 1'b0, 16'hFF08, 32'h0};
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] m, e);
    @(negedge clk);
    req.addr = a;
    #1 chk("register", e, rdata & m);
  endtask : rd
  task automatic pushn(input int n);
    @(negedge clk);
    push = 1'b1;
    repeat (n) @(negedge clk);
    push = 1'b0;
  endtask : pushn
  always @(posedge clk) begin
    cyc++;
    run <= bact ? run + 4'(bpop) : 4'h0;
    if (bact && run + 4'(bpop) > mx) mx <= run + 4'(bpop);
    if (cyc > 6000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    rd(16'hFF00, 32'hFFFFFFFF, 32'h0);
    rd(16'hFF04, 32'h0000380F, 32'h00001008);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].m, rows[i].e);
    end
    wr(16'hFF00, 32'h00000013);
    wr(16'hFF00, 32'h00000003);
    pushn(1);
    rd(16'hFF04, 32'h0000380F, 32'h00002007);
    pushn(6);
    rd(16'hFF04, 32'h0000380F, 32'h00000001);
    pushn(1);
    rd(16'hFF04, 32'h0000380F, 32'h00000800);
    wr(16'hFF00, 32'h00000013);
    rd(16'hFF04, 32'h0000380F, 32'h00001008);
    for (int b = 0; b < 4; b++) begin
      slow = (b != 1);
      wr(16'hFF00, 32'h00000010);
      wr(16'hFF00, 32'h00000001 | (32'(b) << 16));
      wr(16'hFF08, 32'h0000000F);
      mx = 4'h0;
      pushn(8);
      repeat (300) if (words != 8'(8 * b + 8)) @(negedge clk);
      chk("burst length", (b == 3) ? 32'h8 : 32'(b + 1), {28'h0, mx});
      rd(16'hFF08, 32'h00000001, 32'h00000001);
    end
    for (int p = 0; p < 2; p++) begin
      hs = (p == 0);
      vs = (p == 0);
      wr(16'hFF00, 32'h00000015 | (32'(p) * 32'h600));
      wr(16'hFF00, 32'h00000005 | (32'(p) * 32'h600));
      repeat (8) @(negedge clk);
      wr(16'hFF08, 32'h0006000F);
      rd(16'hFF08, 32'h000F000F, 32'h00060000);
      hs = (p == 1);
      vs = (p == 1);
      sda = 1'b0;
      repeat (3) @(negedge clk);
      hs = (p == 0);
      vs = (p == 0);
      sda = 1'b1;
      repeat (10) @(negedge clk);
      rd(16'hFF08, 32'h000F000E, 32'h0006000E);
      chk("irq", 32'h1, {31'h0, irq});
      wr(16'hFF08, 32'h00060002);
      rd(16'hFF08, 32'h000F000E, 32'h0006000C);
    end
    dfl = 1'b1;
    wr(16'hFF00, 32'h00000619);
    wr(16'hFF00, 32'h00000609);
    rd(16'hFF00, 32'h80000000, 32'h00000000);
    pushn(1);
    @(negedge clk);
    chk("pass word", 32'hA5A50000, vw);
    chk("pass valid", 32'h1, {31'h0, vwv});
    chk("drain request", 32'h1, {31'h0, drq});
    wr(16'hFF00, 32'h00000617);
    wr(16'hFF00, 32'h00000607);
    rd(16'hFF00, 32'h80000000, 32'h80000000);
    close_out();
  end
endmodule : lvpc_tb
bind lvpc_top lvpc_checker CHK (.clk(clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .burst_pop(burst_pop), .burst_active(burst_active), .base_address_load(base_address_load),
  .port_clock_select(port_clock_select), .port_clock_invert(port_clock_invert), .port_mode(port_mode), .irq(irq));
`default_nettype wire
